// >>> hw/wet_ep_stop.sv
// per endpoint flag selection and end-of-transaction condition
`timescale 1ns/1ps
module wet_ep_stop
  import wet_pkg::*;
(
  // configuration
  input wire logic stop_on_flag,
  input wire logic [1:0] flag_select_field,
  // status
  input wire wet_pkg::wet_flags_t flags,
  input wire logic tc_expired,
  // result
  output logic selected_flag,
  output logic stop_hit
);
  always_comb begin
    case (flag_select_field)
      FLAG_PROG: selected_flag = flags.prog;
      FLAG_EMPTY: selected_flag = flags.empty;
      FLAG_FULL: selected_flag = flags.full;
      default: selected_flag = 1'b0;
    endcase
    stop_hit = stop_on_flag ? selected_flag : tc_expired;
  end
endmodule : wet_ep_stop

// >>> hw/wet_pkg.sv
// constants, types and register map of the waveform engine trigger registers
package wet_pkg;
  localparam int ADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_EP2_STOP = 16'he6d3;
  localparam logic [15:0] IDX_EP2_TRIG = 16'he6d4;
  localparam logic [15:0] IDX_EP4_STOP = 16'he6db;
  localparam logic [15:0] IDX_EP4_TRIG = 16'he6dc;
  localparam logic [15:0] IDX_EP6_STOP = 16'he6e3;
  localparam logic [15:0] IDX_EP6_TRIG = 16'he6e4;
  localparam logic [15:0] IDX_EP8_STOP = 16'he6eb;
  localparam logic [15:0] IDX_EP8_TRIG = 16'he6ec;
  localparam logic [15:0] IDX_SGL_HIGH = 16'he6f0;
  localparam logic [15:0] IDX_SGL_LOW_TRIG = 16'he6f1;
  localparam logic [15:0] IDX_SGL_LOW_PASSIVE = 16'he6f2;
  localparam logic [15:0] IDX_READY_CFG = 16'he6f3;
  localparam logic [15:0] IDX_FLAG_SELECT = 16'he6f4;
  // field positions
  localparam int STOP_ON_FLAG_BIT = 0;
  localparam int FIRMWARE_READY_BIT = 7;
  localparam int SAMPLING_MODE_BIT = 6;
  localparam int COUNT_EXPIRY_BIT = 5;
  localparam int READY_PIN_5 = 5;
  // reset values
  localparam logic [7:0] STOP_RESET = 8'h00;
  localparam logic [7:0] READY_CFG_RESET = 8'h00;
  localparam logic [7:0] FLAG_SELECT_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_VALUE = 8'hff;
  // flag select and bus response encodings
  localparam logic [1:0] FLAG_PROG = 2'b00;
  localparam logic [1:0] FLAG_EMPTY = 2'b01;
  localparam logic [1:0] FLAG_FULL = 2'b10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    WET_SEL_NONE = 4'b0000,
    WET_SEL_STOP = 4'b0001,
    WET_SEL_TRIG = 4'b0010,
    WET_SEL_SGL_HIGH = 4'b0011,
    WET_SEL_SGL_LOW_TRIG = 4'b0100,
    WET_SEL_SGL_LOW_PASSIVE = 4'b0101,
    WET_SEL_READY_CFG = 4'b0110,
    WET_SEL_FLAG_SELECT = 4'b0111
  } wet_sel_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } wet_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wet_axil_rsp_t;

  // per endpoint fifo flags from the endpoint buffers
  typedef struct packed {
    logic prog;
    logic empty;
    logic full;
  } wet_flags_t;

  // commands to the waveform engine
  typedef struct packed {
    logic fifo_start;
    logic fifo_write;
    logic [1:0] fifo_ep;
    logic single_start;
    logic single_write;
    logic [15:0] single_data;
  } wet_cmd_t;
endpackage : wet_pkg

// >>> hw/wet_ready_in.sv
// ready input conditioning for the waveform engine
`timescale 1ns/1ps
module wet_ready_in
  import wet_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and sources
  input wire logic [5:0] ready_pins,
  input wire logic tc_expired,
  // configuration
  input wire logic firmware_ready,
  input wire logic ready_sampling_mode,
  input wire logic count_expiry_as_ready,
  // results
  output logic [5:0] ready_status,
  output logic [6:0] engine_ready
);
  logic [5:0] sample_reg;
  logic [5:0] sample_next;
  logic [5:0] pin_view;

  always_comb begin
    sample_next = ready_pins;
    pin_view = ready_sampling_mode ? sample_reg : ready_pins;
    engine_ready = {firmware_ready, pin_view};
    if (count_expiry_as_ready) begin
      engine_ready[READY_PIN_5] = tc_expired;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_reg <= 6'h00;
    end else begin
      sample_reg <= sample_next;
    end
  end

  assign ready_status = sample_reg;
endmodule : wet_ready_in

// >>> hw/wet_trigger_regs.sv
// axi4-lite register bank that steers and triggers the waveform engine
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Function
// - with stop-on-flag set, the engine is told to finish as soon as the endpoint's chosen flag rises.
// - with stop-on-flag clear, the engine finishes only when the transaction count expires.
// - writing 0xFF to an endpoint trigger register starts a fifo write transaction from that endpoint.
// - reading an endpoint trigger register starts a fifo read transaction into that endpoint.
// - the single-data high register holds the upper byte driven to or captured from the upper pins.
// - any read, or any write with the low byte lane, of the triggering low register moves the low byte and launches one single transaction.
// - the passive low register returns the low byte without launching anything.
// - the firmware-ready bit is a seventh ready input to the engine, above the six ready pins.
// - with count-expiry-as-ready set, count expiry replaces ready pin 5.
// - each endpoint's two-bit flag select routes exactly one flag: programmable, empty, full, none.
// - the ready pins are sampled on every rising clock edge; with sampling mode set the samples feed the engine, otherwise the live pins do.
module wet_trigger_regs
  import wet_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire wet_pkg::wet_axil_req_t axil_req,
  output wet_pkg::wet_axil_rsp_t axil_rsp,
  // endpoint fifo flags, index 0..3 for endpoints 2, 4, 6, 8
  input wire wet_pkg::wet_flags_t [3:0] ep_flags,
  // engine status
  input wire logic tc_expired,
  input wire logic engine_done,
  input wire logic single_capture_valid,
  input wire logic [15:0] single_capture_data,
  // ready pins
  input wire logic [5:0] ready_pins,
  // engine control
  output wet_pkg::wet_cmd_t engine_cmd,
  output logic engine_stop,
  output logic [6:0] engine_ready,
  output logic [5:0] ready_status
);
  // write and read channel state of the register bus
  logic aw_held_reg, aw_held_next;
  logic [15:0] aw_idx_reg, aw_idx_next;
  logic w_held_reg, w_held_next;
  logic [7:0] w_data_reg, w_data_next;
  logic w_lane_reg, w_lane_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // software visible configuration
  logic [3:0] stop_reg, stop_next;
  logic [7:0] flag_sel_reg, flag_sel_next;
  logic [2:0] ready_cfg_reg, ready_cfg_next;
  // single transfer data and the running fifo transaction
  logic [15:0] single_data_reg, single_data_next;
  logic [1:0] active_ep_reg, active_ep_next;
  logic fifo_active_reg, fifo_active_next;
  wet_cmd_t cmd_reg, cmd_next;
  // decode of the held write and the live read
  logic [3:0] stop_hit;
  logic do_wr, do_rd;
  wet_sel_t wr_sel, rd_sel;
  logic [1:0] wr_ep, rd_ep;
  logic [15:0] rd_idx;

  // map an index to a register kind and endpoint
  function automatic wet_sel_t decode(input logic [15:0] idx);
    case (idx)
      IDX_EP2_STOP, IDX_EP4_STOP, IDX_EP6_STOP, IDX_EP8_STOP: decode = WET_SEL_STOP;
      IDX_EP2_TRIG, IDX_EP4_TRIG, IDX_EP6_TRIG, IDX_EP8_TRIG: decode = WET_SEL_TRIG;
      IDX_SGL_HIGH: decode = WET_SEL_SGL_HIGH;
      IDX_SGL_LOW_TRIG: decode = WET_SEL_SGL_LOW_TRIG;
      IDX_SGL_LOW_PASSIVE: decode = WET_SEL_SGL_LOW_PASSIVE;
      IDX_READY_CFG: decode = WET_SEL_READY_CFG;
      IDX_FLAG_SELECT: decode = WET_SEL_FLAG_SELECT;
      default: decode = WET_SEL_NONE;
    endcase
  endfunction : decode

  // endpoint index of a stop or trigger register, 0..3 for endpoints 2, 4, 6, 8
  function automatic logic [1:0] ep_of(input logic [15:0] idx);
    case (idx)
      IDX_EP4_STOP, IDX_EP4_TRIG: ep_of = 2'h1;
      IDX_EP6_STOP, IDX_EP6_TRIG: ep_of = 2'h2;
      IDX_EP8_STOP, IDX_EP8_TRIG: ep_of = 2'h3;
      default: ep_of = 2'h0;
    endcase
  endfunction : ep_of

  // one flag selector and stop condition per endpoint
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ep
      wet_ep_stop u_stop (
        .stop_on_flag(stop_reg[g]),
        .flag_select_field(flag_sel_reg[2*g +: 2]),
        .flags(ep_flags[g]),
        .tc_expired(tc_expired),
        .selected_flag(),
        .stop_hit(stop_hit[g])
      );
    end
  endgenerate

  // ready inputs as the engine sees them
  wet_ready_in u_ready (
    .aclk(aclk),
    .aresetn(aresetn),
    .ready_pins(ready_pins),
    .tc_expired(tc_expired),
    .firmware_ready(ready_cfg_reg[2]),
    .ready_sampling_mode(ready_cfg_reg[1]),
    .count_expiry_as_ready(ready_cfg_reg[0]),
    .ready_status(ready_status),
    .engine_ready(engine_ready)
  );

  assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
  // reads wait while a write is being applied, so two starts never meet
  assign do_rd = axil_req.arvalid && !rvalid_reg && !do_wr;
  assign rd_idx = axil_req.araddr[ADDR_W-1:2];
  assign wr_sel = decode(aw_idx_reg);
  assign rd_sel = decode(rd_idx);
  assign wr_ep = ep_of(aw_idx_reg);
  assign rd_ep = ep_of(rd_idx);

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_idx_next = aw_idx_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    stop_next = stop_reg;
    flag_sel_next = flag_sel_reg;
    ready_cfg_next = ready_cfg_reg;
    single_data_next = single_data_reg;
    active_ep_next = active_ep_reg;
    fifo_active_next = fifo_active_reg;
    cmd_next = cmd_reg;
    cmd_next.fifo_start = 1'b0;
    cmd_next.single_start = 1'b0;
    // write address and data are taken independently
    if (axil_req.awvalid && !aw_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b1;
      aw_idx_next = axil_req.awaddr[ADDR_W-1:2];
    end
    if (axil_req.wvalid && !w_held_reg && !bvalid_reg) begin
      w_held_next = 1'b1;
      w_data_next = axil_req.wdata[7:0];
      w_lane_next = axil_req.wstrb[0];
    end
    if (bvalid_reg && axil_req.bready) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && axil_req.rready) begin
      rvalid_next = 1'b0;
    end
    // the engine ends the running fifo transaction; a new start below wins
    if (engine_done) begin
      fifo_active_next = 1'b0;
    end
    // engine capture of a single read; a register write below overrides the byte it writes
    if (single_capture_valid) begin
      single_data_next = single_capture_data;
    end
    if (do_wr) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      // unmapped indices answer with an error and change nothing
      bresp_next = (wr_sel == WET_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // a write without the low byte lane completes with no effect
      if (w_lane_reg) begin
        case (wr_sel)
          // only the stop-on-flag bit is stored; the rest read as zero
          WET_SEL_STOP: stop_next[wr_ep] = w_data_reg[STOP_ON_FLAG_BIT];
          WET_SEL_TRIG: begin
            // any other value is accepted and ignored
            if (w_data_reg == TRIGGER_VALUE) begin
              cmd_next.fifo_start = 1'b1;
              cmd_next.fifo_write = 1'b1;
              cmd_next.fifo_ep = wr_ep;
              active_ep_next = wr_ep;
              fifo_active_next = 1'b1;
            end
          end
          WET_SEL_SGL_HIGH: single_data_next[15:8] = w_data_reg;
          WET_SEL_SGL_LOW_TRIG: begin
            single_data_next[7:0] = w_data_reg;
            cmd_next.single_start = 1'b1;
            cmd_next.single_write = 1'b1;
          end
          WET_SEL_READY_CFG: begin
            ready_cfg_next = {w_data_reg[FIRMWARE_READY_BIT], w_data_reg[SAMPLING_MODE_BIT],
                              w_data_reg[COUNT_EXPIRY_BIT]};
          end
          WET_SEL_FLAG_SELECT: flag_sel_next = w_data_reg;
          default: ;
        endcase
      end
    end
    // a read is taken in one cycle and answered from the next edge
    if (do_rd) begin
      rvalid_next = 1'b1;
      rresp_next = (rd_sel == WET_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_next = 8'h00;
      case (rd_sel)
        WET_SEL_STOP: rdata_next[STOP_ON_FLAG_BIT] = stop_reg[rd_ep];
        // a trigger read returns zero and starts a fifo read
        WET_SEL_TRIG: begin
          cmd_next.fifo_start = 1'b1;
          cmd_next.fifo_write = 1'b0;
          cmd_next.fifo_ep = rd_ep;
          active_ep_next = rd_ep;
          fifo_active_next = 1'b1;
        end
        WET_SEL_SGL_HIGH: rdata_next = single_data_reg[15:8];
        WET_SEL_SGL_LOW_TRIG: begin
          rdata_next = single_data_reg[7:0];
          cmd_next.single_start = 1'b1;
          cmd_next.single_write = 1'b0;
        end
        WET_SEL_SGL_LOW_PASSIVE: rdata_next = single_data_reg[7:0];
        WET_SEL_READY_CFG: begin
          rdata_next[FIRMWARE_READY_BIT] = ready_cfg_reg[2];
          rdata_next[SAMPLING_MODE_BIT] = ready_cfg_reg[1];
          rdata_next[COUNT_EXPIRY_BIT] = ready_cfg_reg[0];
        end
        WET_SEL_FLAG_SELECT: rdata_next = flag_sel_reg;
        default: ;
      endcase
    end
    // the engine sees the data as they stand after this cycle
    cmd_next.single_data = single_data_next;
  end

  // undocumented reset contents are cleared so nothing unknown reaches the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rresp_reg <= RESP_OKAY;
      stop_reg <= {STOP_RESET[STOP_ON_FLAG_BIT], STOP_RESET[STOP_ON_FLAG_BIT],
                   STOP_RESET[STOP_ON_FLAG_BIT], STOP_RESET[STOP_ON_FLAG_BIT]};
      flag_sel_reg <= FLAG_SELECT_RESET;
      ready_cfg_reg <= {READY_CFG_RESET[FIRMWARE_READY_BIT], READY_CFG_RESET[SAMPLING_MODE_BIT],
                        READY_CFG_RESET[COUNT_EXPIRY_BIT]};
      single_data_reg <= 16'h0000;
      active_ep_reg <= 2'h0;
      fifo_active_reg <= 1'b0;
      cmd_reg <= '0;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_idx_reg <= aw_idx_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      stop_reg <= stop_next;
      flag_sel_reg <= flag_sel_next;
      ready_cfg_reg <= ready_cfg_next;
      single_data_reg <= single_data_next;
      active_ep_reg <= active_ep_next;
      fifo_active_reg <= fifo_active_next;
      cmd_reg <= cmd_next;
    end
  end

  // finish request for the running fifo transaction
  assign engine_stop = fifo_active_reg && stop_hit[active_ep_reg];
  assign engine_cmd = cmd_reg;

  // readies come from registers only, so no path runs from a valid to a ready
  always_comb begin
    axil_rsp.awready = !aw_held_reg && !bvalid_reg;
    axil_rsp.wready = !w_held_reg && !bvalid_reg;
    axil_rsp.bvalid = bvalid_reg;
    axil_rsp.bresp = bresp_reg;
    axil_rsp.arready = !rvalid_reg && !do_wr;
    axil_rsp.rvalid = rvalid_reg;
    axil_rsp.rdata = {24'h00_0000, rdata_reg};
    axil_rsp.rresp = rresp_reg;
  end
endmodule : wet_trigger_regs

// >>> sim/waveform_engine_trigger_regs_test.sv
// self-checking testbench of the waveform engine trigger registers
`timescale 1ns/1ps
module waveform_engine_trigger_regs_test;
  import wet_pkg::*;
  localparam logic [15:0] STOPS [4] = '{IDX_EP2_STOP, IDX_EP4_STOP, IDX_EP6_STOP, IDX_EP8_STOP};
  localparam logic [15:0] TRIGS [4] = '{IDX_EP2_TRIG, IDX_EP4_TRIG, IDX_EP6_TRIG, IDX_EP8_TRIG};
  logic aclk, aresetn, tc_expired, engine_done, cap_valid, engine_stop;
  wet_axil_req_t req;
  wet_axil_rsp_t rsp;
  wet_flags_t [3:0] ep_flags;
  logic [15:0] cap_data;
  logic [5:0] ready_pins, ready_status, smp;
  logic [6:0] engine_ready;
  wet_cmd_t cmd, lf, ls;
  int mismatches, compares, fcnt, scnt;
  wet_trigger_regs i_wet_trigger_regs (.aclk, .aresetn, .axil_req(req), .axil_rsp(rsp),
    .ep_flags, .tc_expired, .engine_done, .single_capture_valid(cap_valid),
    .single_capture_data(cap_data), .ready_pins, .engine_cmd(cmd), .engine_stop,
    .engine_ready, .ready_status);
  wet_periph_model i_wet_periph_model (.aclk, .ready_pins);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) smp <= ready_pins;
  always @(negedge aclk) begin
    if (cmd.fifo_start === 1'b1) begin
      fcnt++;
      lf = cmd;
    end
    if (cmd.single_start === 1'b1) begin
      scnt++;
      ls = cmd;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, da, dw, tb;
    da = 1'b0;
    dw = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h00_0000, d};
    do begin
      @(negedge aclk);
      ta = !da && rsp.awready;
      tw = !dw && rsp.wready;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end while (!(da && dw));
    do begin
      @(negedge aclk);
      tb = rsp.bvalid;
      ta = rsp.bresp[0];
      tw = rsp.bresp[1];
      @(posedge aclk);
    end while (tb !== 1'b1);
    chk("bresp", er, {tw, ta});
  endtask : wr
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    do begin
      @(negedge aclk);
      t = rsp.arready;
      @(posedge aclk);
    end while (t !== 1'b1);
    req.arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
    end while (t !== 1'b1);
    chk("rresp", er, r);
    if (er == RESP_OKAY) chk("rdata", {24'h00_0000, e}, d);
  endtask : rdchk
  function automatic logic exp_stop(logic pf, logic [1:0] fs, wet_flags_t f, logic tc);
    logic [3:0] m;
    m = {1'b0, f.full, f.empty, f.prog};
    return pf ? m[fs] : tc;
  endfunction : exp_stop
  function automatic logic [6:0] exp_rdy(logic [2:0] c, logic tc, logic [5:0] p, logic [5:0] s);
    logic [5:0] v;
    v = c[1] ? s : p;
    if (c[0]) v[5] = tc;
    return {c[2], v};
  endfunction : exp_rdy
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end
  initial begin
    logic [7:0] d8, h, l;
    logic [15:0] c;
    int n;
    wet_flags_t [3:0] f;
    void'($urandom(39324));
    req = '0;
    req.wstrb = 4'hf;
    req.bready = 1'b1;
    req.rready = 1'b1;
    {aresetn, tc_expired, engine_done, cap_valid, cap_data, ep_flags} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int g = 0; g < 4; g++) rdchk(STOPS[g], STOP_RESET, RESP_OKAY);
    rdchk(IDX_READY_CFG, READY_CFG_RESET, RESP_OKAY);
    $display("test reset values done");
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 8; k++) begin
        d8 = 8'($urandom);
        d8[0] = k[2];
        wr(STOPS[g], d8, RESP_OKAY);
        rdchk(STOPS[g], {7'h00, k[2]}, RESP_OKAY);
        wr(IDX_FLAG_SELECT, 8'({6'h00, k[1:0]} << (2 * g)), RESP_OKAY);
        n = fcnt;
        wr(TRIGS[g], 8'($urandom) & 8'hfe, RESP_OKAY);
        wr(TRIGS[g], TRIGGER_VALUE, RESP_OKAY);
        chk("fifo starts", n + 1, fcnt);
        chk("fifo cmd", {1'b1, 2'(g)}, {lf.fifo_write, lf.fifo_ep});
        for (int v = 0; v < 16; v++) begin
          f = {4{3'b111}};
          f[g] = v[2:0];
          ep_flags <= f;
          tc_expired <= v[3];
          @(negedge aclk);
          chk("stop", exp_stop(k[2], k[1:0], f[g], v[3]), engine_stop);
          @(posedge aclk);
        end
        ep_flags <= '0;
        tc_expired <= 1'b0;
        rdchk(TRIGS[g], 8'h00, RESP_OKAY);
        chk("fifo reads", n + 2, fcnt);
        chk("fifo read", {1'b0, 2'(g)}, {lf.fifo_write, lf.fifo_ep});
        engine_done <= 1'b1;
        @(posedge aclk);
        engine_done <= 1'b0;
        tc_expired <= 1'b1;
        @(negedge aclk);
        chk("stop idle", 1'b0, engine_stop);
        @(posedge aclk);
        tc_expired <= 1'b0;
      end
    end
    $display("test endpoint stop and trigger done");
    for (int i = 0; i < 4; i++) begin
      h = 8'($urandom);
      l = 8'($urandom);
      c = 16'($urandom);
      n = scnt;
      wr(IDX_SGL_HIGH, h, RESP_OKAY);
      wr(IDX_SGL_LOW_TRIG, l, RESP_OKAY);
      chk("single writes", n + 1, scnt);
      chk("single write", {1'b1, h, l}, {ls.single_write, ls.single_data});
      rdchk(IDX_SGL_LOW_PASSIVE, l, RESP_OKAY);
      rdchk(IDX_SGL_HIGH, h, RESP_OKAY);
      rdchk(IDX_SGL_LOW_TRIG, l, RESP_OKAY);
      chk("single reads", n + 2, scnt);
      chk("single read", 1'b0, ls.single_write);
      cap_data <= c;
      cap_valid <= 1'b1;
      @(posedge aclk);
      cap_valid <= 1'b0;
      rdchk(IDX_SGL_HIGH, c[15:8], RESP_OKAY);
      rdchk(IDX_SGL_LOW_PASSIVE, c[7:0], RESP_OKAY);
    end
    $display("test single data done");
    for (int k = 0; k < 8; k++) begin
      wr(IDX_READY_CFG, {k[2:0], 5'h1f}, RESP_OKAY);
      rdchk(IDX_READY_CFG, {k[2:0], 5'h00}, RESP_OKAY);
      repeat (6) begin
        tc_expired <= 1'($urandom);
        @(negedge aclk);
        chk("ready status", smp, ready_status);
        chk("ready view", exp_rdy(k[2:0], tc_expired, ready_pins, smp), engine_ready);
        @(posedge aclk);
      end
    end
    $display("test ready config done");
    wr(16'h0001, 8'h55, RESP_SLVERR);
    rdchk(16'h0001, 8'h00, RESP_SLVERR);
    $display("test unmapped done");
    give_verdict();
  end
endmodule : waveform_engine_trigger_regs_test

// >>> sim/wet_periph_model.sv
// model of the external peripheral that drives the ready pins
`timescale 1ns/1ps
module wet_periph_model (
  // clock
  input wire logic aclk,
  // pins
  output logic [5:0] ready_pins
);
  initial ready_pins = 6'h00;
  // a free running peripheral moves its pins just after every rising edge
  always @(posedge aclk) ready_pins <= 6'($urandom);
endmodule : wet_periph_model

// >>> sim/wet_trigger_regs_props.sv
// assertion checker for the waveform engine trigger registers
`timescale 1ns/1ps
module wet_trigger_regs_props
  import wet_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire wet_pkg::wet_axil_req_t axil_req,
  input wire wet_pkg::wet_axil_rsp_t axil_rsp,
  // engine side
  input wire wet_pkg::wet_flags_t [3:0] ep_flags,
  input wire logic tc_expired,
  input wire logic engine_done,
  input wire logic single_capture_valid,
  input wire logic [15:0] single_capture_data,
  input wire logic [5:0] ready_pins,
  input wire wet_pkg::wet_cmd_t engine_cmd,
  input wire logic engine_stop,
  input wire logic [6:0] engine_ready,
  input wire logic [5:0] ready_status
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic ar_hs;
  logic [15:0] ar_idx;
  logic [15:0] trig_off;
  assign ar_hs = axil_req.arvalid && axil_rsp.arready;
  assign ar_idx = axil_req.araddr[17:2];
  // trigger indices sit eight apart from the first one
  assign trig_off = ar_idx - IDX_EP2_TRIG;
  AST_FIFO_PULSE: assert property (engine_cmd.fifo_start |=> !engine_cmd.fifo_start)
    else $error("fifo start wider than one cycle");
  AST_SGL_PULSE: assert property (engine_cmd.single_start |=> !engine_cmd.single_start)
    else $error("single start wider than one cycle");
  AST_TRIG_READ: assert property (ar_hs && trig_off[15:5] == 0 && trig_off[2:0] == 0 |=>
    engine_cmd.fifo_start && !engine_cmd.fifo_write && engine_cmd.fifo_ep == $past(trig_off[4:3]))
    else $error("trigger read did not start a fifo read");
  AST_LOW_TRIG_READ: assert property (ar_hs && ar_idx == IDX_SGL_LOW_TRIG |=>
    engine_cmd.single_start && !engine_cmd.single_write)
    else $error("low byte read did not launch a single read");
  AST_PASSIVE_READ: assert property (ar_hs && ar_idx == IDX_SGL_LOW_PASSIVE |=>
    !engine_cmd.single_start)
    else $error("passive read launched a transaction");
  AST_STATUS_SAMPLE: assert property ($past(aresetn) |-> ready_status == $past(ready_pins))
    else $error("ready status is not last edge sample");
  AST_STOP_CAUSE: assert property (engine_stop |-> tc_expired || (|ep_flags))
    else $error("stop without flag or count expiry");
  AST_STOP_CLEAR: assert property (engine_done |=> !engine_stop || engine_cmd.fifo_start)
    else $error("stop stays after engine done");
  AST_WRITE_RESP: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid
    && axil_rsp.wready |-> ##2 axil_rsp.bvalid)
    else $error("write response late");
  AST_RDATA_UPPER: assert property (axil_rsp.rvalid |-> axil_rsp.rdata[31:8] == 0)
    else $error("read data upper bits not zero");
endmodule : wet_trigger_regs_props

bind wet_trigger_regs wet_trigger_regs_props i_wet_trigger_regs_props (.aclk, .aresetn,
  .axil_req, .axil_rsp, .ep_flags, .tc_expired, .engine_done, .single_capture_valid,
  .single_capture_data, .ready_pins, .engine_cmd, .engine_stop, .engine_ready, .ready_status);
